// ==== rtl/rcpc_top.sv ====
// Summary of operation
// - config word resets 8008h, bit7 enables tx register
// - bit6 fifo mode, else data pins drive
// - load cap 8.5 pF plus 0.5 pF steps
// - power word resets 8208h, bit7 whole receiver
// - bit6 baseband on independently
// - bit5 pll and pa, starts tx register
// - bit4 synthesizer, bit3 oscillator independently
// - bit2 battery detector, bit1 wake-up timer
// - bit0 set stops clock output buffer
// - both chains set means receive mode
// - synth needs oscillator, baseband needs synth
// - receive chain forces oscillator, synth, baseband, front
// - transmit chain forces oscillator, synth, amplifier
// - baseband already on skips its calibration
// - clearing oscillator gives 192 tail pulses
// - tail only after prior status read
// - pending interrupt forces oscillator on
// - interrupts cleared plus status read stops auto oscillator
// - active interrupt blocks oscillator turn-off
// - clock disable kills tail and auto control
`timescale 1ns/1ps
`include "rcpc_defs.svh"

module rcpc_top (
  // system clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  // serial command link
  input  wire logic       spi_sck_i,
  input  wire logic       spi_sel_n_i,
  input  wire logic       spi_sdi_i,
  // pending interrupt from the interrupt logic
  input  wire logic       irq_pending_i,
  // configuration outputs
  output logic            tx_data_register_enable_o,
  output logic            fifo_mode_enable_o,
  output logic            data_pin_out_en_o,
  output logic [1:0]      band_select_o,
  output logic            band_valid_o,
  output logic [3:0]      xtal_load_cap_o,
  output logic [5:0]      xtal_load_halfpf_o,
  // analog enables
  output logic            xtal_osc_run_o,
  output logic            synth_en_o,
  output logic            baseband_en_o,
  output logic            rx_frontend_en_o,
  output logic            pa_en_o,
  output logic            rx_mode_o,
  output logic            tx_mode_o,
  output logic            tx_start_o,
  output logic            low_batt_detect_en_o,
  output logic            wakeup_timer_en_o,
  output logic            clk_out_en_o,
  // calibration and status pulses
  output logic            bb_cal_start_o,
  output logic            bb_cal_skip_o,
  output logic            status_read_o
);

  //////////////////////////////////////////////////////////////////
  // link domain: shift in 16-bit commands on the serial clock
  //////////////////////////////////////////////////////////////////

  logic        frame_rst;    // select high ends the frame
  logic [3:0]  bit_cnt_q;    // bit position inside frame
  logic [14:0] shift_q;      // bits received so far
  logic [15:0] hold_q;       // last complete command
  logic        tgl_q;        // flips once per command

  // select high or system reset clears the frame state
  assign frame_rst = rst_i | spi_sel_n_i;

  // bit counter and shifter, live only inside a frame
  always_ff @(posedge spi_sck_i or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt_q <= 4'h0;
      shift_q   <= 15'h0000;
    end else begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
      shift_q   <= {shift_q[13:0], spi_sdi_i};
    end
  end

  // hold_q only changes at the end of a frame, long before the toggle
  // reaches the strobe, so the word is settled when the system side reads it
  // complete word is held and announced by a toggle
  always_ff @(posedge spi_sck_i or posedge rst_i) begin
    if (rst_i) begin
      hold_q <= 16'h0000;
      tgl_q  <= 1'b0;
    end else if (!spi_sel_n_i && bit_cnt_q == `RCPC_LAST_BIT) begin
      // the sixteenth bit closes the command
      hold_q <= {shift_q, spi_sdi_i};
      tgl_q  <= ~tgl_q;
    end
  end

  //////////////////////////////////////////////////////////////////
  // crossing: toggle synchroniser, word is stable when seen
  //////////////////////////////////////////////////////////////////

  logic tgl_s1_q;   // first stage, read only by second
  logic tgl_s2_q;   // second stage
  logic tgl_s3_q;   // previous value for edge detect
  logic word_stb;   // one cycle per received command

  // three flops: two to synchronise, one to find the change
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
    end else begin
      tgl_s1_q <= tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
    end
  end

  // a change on the synchronised toggle marks a new word
  assign word_stb = tgl_s2_q ^ tgl_s3_q;

  //////////////////////////////////////////////////////////////////
  // command decode and the two command words
  //////////////////////////////////////////////////////////////////

  logic [15:0] cfg_q;     // radio_configuration_word
  logic [15:0] pwr_q;     // power_enable_word
  logic        stat_rd;   // status read command seen

  // a clear top bit marks a status read
  assign stat_rd = word_stb && !hold_q[`RCPC_STAT_BIT];

  // configuration word, only on its own prefix
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_q <= `RCPC_CFG_RESET;
    end else if (word_stb && hold_q[15:8] == `RCPC_CFG_PREFIX) begin
      cfg_q <= hold_q;
    end
  end

  // power word, only on its own prefix
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pwr_q <= `RCPC_PWR_RESET;
    end else if (word_stb && hold_q[15:8] == `RCPC_PWR_PREFIX) begin
      pwr_q <= hold_q;
    end
  end

  //////////////////////////////////////////////////////////////////
  // power dependency logic
  //////////////////////////////////////////////////////////////////

  logic rx_on;      // receive chain bit
  logic tx_on;      // transmit chain bit
  logic ck_dis;     // clock output disabled
  logic auto_en;    // tail and auto oscillator allowed
  logic rx_d;       // receive mode
  logic tx_d;       // transmit mode
  logic osc_req;    // something needs the oscillator
  logic osc_run_d;  // oscillator running next cycle
  logic syn_d;      // effective synthesizer enable
  logic bb_d;       // effective baseband enable
  logic fe_d;       // front end enable
  logic pa_d;       // power amplifier enable

  // raw fields of the power word
  assign rx_on   = pwr_q[`RCPC_PWR_RX];
  assign tx_on   = pwr_q[`RCPC_PWR_TX];
  assign ck_dis  = pwr_q[`RCPC_PWR_CKD];
  assign auto_en = ~ck_dis;

  // receive wins when both chains are requested
  assign rx_d = rx_on;
  assign tx_d = tx_on & ~rx_on;

  //////////////////////////////////////////////////////////////////
  // oscillator control: auto start, clock tail
  //////////////////////////////////////////////////////////////////

  rcpc_pkg::rcpc_osc_t osc_q;    // controller state
  rcpc_pkg::rcpc_osc_t osc_d;    // next state
  logic [7:0]          tail_q;   // tail pulses still to give
  logic [7:0]          tail_d;   // next tail count
  logic                auto_q;   // oscillator was started by irq
  logic                seen_q;   // status read since last on

  // interrupt start is sticky until cleared and status read
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      auto_q <= 1'b0;
    end else if (auto_en && irq_pending_i) begin
      auto_q <= 1'b1;
    end else if (!auto_en || stat_rd) begin
      // release on a status read with no interrupt left, or at once when the clock output is disabled
      auto_q <= 1'b0;
    end
  end

  // a status read arms the tail; a new read wins over consumption
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      seen_q <= 1'b0;
    end else if (stat_rd) begin
      seen_q <= 1'b1;
    end else if (osc_q == rcpc_pkg::RCPC_OSC_ON && !osc_req) begin
      seen_q <= 1'b0;
    end
  end

  // chains, the oscillator bit and interrupts keep it running
  assign osc_req = pwr_q[`RCPC_PWR_XO] | rx_on | tx_on
                 | (auto_en & (irq_pending_i | auto_q));

  // next state and tail count
  always_comb begin
    osc_d  = osc_q;
    tail_d = tail_q;
    case (osc_q)
      rcpc_pkg::RCPC_OSC_OFF: begin
        // start as soon as anything asks
        if (osc_req) begin
          osc_d = rcpc_pkg::RCPC_OSC_ON;
        end
      end
      rcpc_pkg::RCPC_OSC_ON: begin
        // nothing asks for the oscillator any more
        if (!osc_req) begin
          if (auto_en && seen_q) begin
            // delayed shutdown with output pulses
            osc_d  = rcpc_pkg::RCPC_OSC_TAIL;
            tail_d = `RCPC_TAIL_PULSES - 8'd1;
          end else begin
            // no prior read or no clock output: stop now
            osc_d = rcpc_pkg::RCPC_OSC_OFF;
          end
        end
      end
      rcpc_pkg::RCPC_OSC_TAIL: begin
        if (osc_req) begin
          // request returned during the tail
          osc_d = rcpc_pkg::RCPC_OSC_ON;
        end else if (tail_q == 8'd0) begin
          osc_d = rcpc_pkg::RCPC_OSC_OFF;
        end else begin
          tail_d = tail_q - 8'd1;
        end
      end
      default: begin
        osc_d = rcpc_pkg::RCPC_OSC_OFF;
      end
    endcase
  end

  // state and counter registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      // the reset power word has the oscillator bit set, so start on
      osc_q  <= rcpc_pkg::RCPC_OSC_ON;
      tail_q <= 8'd0;
    end else begin
      osc_q  <= osc_d;
      tail_q <= tail_d;
    end
  end

  // oscillator runs in on and tail states
  assign osc_run_d = (osc_d != rcpc_pkg::RCPC_OSC_OFF);

  // synthesizer needs a running oscillator
  assign syn_d = (pwr_q[`RCPC_PWR_SYN] | rx_on | tx_on) & osc_run_d;

  // baseband needs the synthesizer
  assign bb_d = (pwr_q[`RCPC_PWR_BB] | rx_on) & syn_d;

  // front end in receive, amplifier in transmit
  assign fe_d = rx_d & syn_d;
  assign pa_d = tx_d & syn_d;

  //////////////////////////////////////////////////////////////////
  // registered outputs: power side
  //////////////////////////////////////////////////////////////////

  // analog enables and mode flags
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      xtal_osc_run_o   <= 1'b1;
      synth_en_o       <= 1'b0;
      baseband_en_o    <= 1'b0;
      rx_frontend_en_o <= 1'b0;
      pa_en_o          <= 1'b0;
      rx_mode_o        <= 1'b0;
      tx_mode_o        <= 1'b0;
    end else begin
      xtal_osc_run_o   <= osc_run_d;
      synth_en_o       <= syn_d;
      baseband_en_o    <= bb_d;
      rx_frontend_en_o <= fe_d;
      pa_en_o          <= pa_d;
      rx_mode_o        <= rx_d;
      tx_mode_o        <= tx_d;
    end
  end

  // transmit start, detector, timer and clock output
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tx_start_o           <= 1'b0;
      low_batt_detect_en_o <= 1'b0;
      wakeup_timer_en_o    <= 1'b0;
      clk_out_en_o         <= 1'b1;
    end else begin
      tx_start_o           <= pa_d & cfg_q[`RCPC_CFG_TXREG];
      low_batt_detect_en_o <= pwr_q[`RCPC_PWR_LBD];
      wakeup_timer_en_o    <= pwr_q[`RCPC_PWR_WUT];
      clk_out_en_o         <= osc_run_d & ~ck_dis;
    end
  end

  // baseband calibration pulses and status read pulse
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      bb_cal_start_o <= 1'b0;
      bb_cal_skip_o  <= 1'b0;
      status_read_o  <= 1'b0;
    end else begin
      // calibrate only when the baseband powers up
      bb_cal_start_o <= bb_d & ~baseband_en_o;
      // entering receive with baseband already up
      bb_cal_skip_o  <= fe_d & ~rx_frontend_en_o & baseband_en_o;
      status_read_o  <= stat_rd;
    end
  end

  //////////////////////////////////////////////////////////////////
  // registered outputs: configuration side
  //////////////////////////////////////////////////////////////////

  // fields of the configuration word
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tx_data_register_enable_o <= 1'b0;
      fifo_mode_enable_o        <= 1'b0;
      data_pin_out_en_o         <= 1'b1;
      band_select_o             <= rcpc_pkg::RCPC_BAND_RSVD;
      band_valid_o              <= 1'b0;
      xtal_load_cap_o           <= 4'h8;
      xtal_load_halfpf_o        <= 6'h19;
    end else begin
      tx_data_register_enable_o <= cfg_q[`RCPC_CFG_TXREG];
      fifo_mode_enable_o        <= cfg_q[`RCPC_CFG_FIFO];
      // data and recovered clock pins drive when fifo is off
      data_pin_out_en_o         <= ~cfg_q[`RCPC_CFG_FIFO];
      band_select_o             <= cfg_q[`RCPC_CFG_BAND_HI:`RCPC_CFG_BAND_LO];
      band_valid_o              <= (cfg_q[`RCPC_CFG_BAND_HI:`RCPC_CFG_BAND_LO]
                                    != rcpc_pkg::RCPC_BAND_RSVD);
      xtal_load_cap_o           <= cfg_q[`RCPC_CFG_CAP_HI:`RCPC_CFG_CAP_LO];
      // half picofarad units: base code plus the field
      xtal_load_halfpf_o        <= `RCPC_CAP_BASE
                                 + {2'h0, cfg_q[`RCPC_CFG_CAP_HI:`RCPC_CFG_CAP_LO]};
    end
  end

endmodule

// ==== rtl/rcpc_defs.svh ====
`ifndef RCPC_DEFS_SVH
`define RCPC_DEFS_SVH
// command words: reset values and prefixes
`define RCPC_CFG_RESET    16'h8008
`define RCPC_PWR_RESET    16'h8208
`define RCPC_CFG_PREFIX   8'h80
`define RCPC_PWR_PREFIX   8'h82
`define RCPC_STAT_BIT     15
// configuration word fields
`define RCPC_CFG_TXREG    7
`define RCPC_CFG_FIFO     6
`define RCPC_CFG_BAND_HI  5
`define RCPC_CFG_BAND_LO  4
`define RCPC_CFG_CAP_HI   3
`define RCPC_CFG_CAP_LO   0
// power word fields
`define RCPC_PWR_RX       7
`define RCPC_PWR_BB       6
`define RCPC_PWR_TX       5
`define RCPC_PWR_SYN      4
`define RCPC_PWR_XO       3
`define RCPC_PWR_LBD      2
`define RCPC_PWR_WUT      1
`define RCPC_PWR_CKD      0
// serial frame length
`define RCPC_LAST_BIT     4'hf
// load capacitance base in half picofarads (8.5 pF)
`define RCPC_CAP_BASE     6'h11
// clock tail length in output clock pulses
`define RCPC_TAIL_PULSES  8'd192
`endif

// ==== rtl/rcpc_pkg.sv ====
package rcpc_pkg;
  // oscillator controller states, gray along off-on-tail
  typedef enum logic [1:0] {
    RCPC_OSC_OFF  = 2'h0,
    RCPC_OSC_ON   = 2'h1,
    RCPC_OSC_TAIL = 2'h3
  } rcpc_osc_t;
  // frequency band codes
  typedef enum logic [1:0] {
    RCPC_BAND_RSVD = 2'h0,
    RCPC_BAND_433  = 2'h1,
    RCPC_BAND_868  = 2'h2,
    RCPC_BAND_915  = 2'h3
  } rcpc_band_t;
endpackage

// ==== testbench/rcpc_top_asserts.sv ====
`timescale 1ns/1ps
module rcpc_top_asserts (
  // clock and reset
  input wire logic       clock_i,
  input wire logic       rst_i,
  // interrupt request
  input wire logic       irq_pending_i,
  // configuration outputs
  input wire logic       tx_data_register_enable_o,
  input wire logic       fifo_mode_enable_o,
  input wire logic       data_pin_out_en_o,
  input wire logic [1:0] band_select_o,
  input wire logic       band_valid_o,
  input wire logic [3:0] xtal_load_cap_o,
  input wire logic [5:0] xtal_load_halfpf_o,
  // analog enables
  input wire logic       xtal_osc_run_o,
  input wire logic       synth_en_o,
  input wire logic       baseband_en_o,
  input wire logic       rx_frontend_en_o,
  input wire logic       pa_en_o,
  input wire logic       rx_mode_o,
  input wire logic       tx_mode_o,
  input wire logic       tx_start_o,
  input wire logic       clk_out_en_o,
  // calibration pulses
  input wire logic       bb_cal_start_o,
  input wire logic       bb_cal_skip_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // an interrupt seen while the clock output runs
  sequence s_irq;
    irq_pending_i && clk_out_en_o;
  endsequence
  // oscillator kept running for two cycles
  sequence s_keep;
    xtal_osc_run_o [*2];
  endsequence
  //////////////////////////////////////////////////////////////////////
  a_synth_osc: assert property (synth_en_o |-> xtal_osc_run_o)
    else $error("synth on without oscillator");
  a_bb_synth: assert property (baseband_en_o |-> synth_en_o)
    else $error("baseband on without synth");
  a_rx_prio: assert property (rx_mode_o |-> !tx_mode_o && !pa_en_o)
    else $error("transmit active in receive mode");
  a_rx_forces: assert property (rx_mode_o && xtal_osc_run_o |->
    synth_en_o && baseband_en_o && rx_frontend_en_o) else $error("rx chain not forced");
  a_tx_forces: assert property (tx_mode_o && xtal_osc_run_o |->
    synth_en_o && pa_en_o) else $error("tx chain not forced");
  a_clk_gate: assert property (clk_out_en_o |-> xtal_osc_run_o)
    else $error("clock out without oscillator");
  a_irq_wake: assert property (s_irq |=> s_keep)
    else $error("interrupt did not keep oscillator");
  a_data_pins: assert property (data_pin_out_en_o == !fifo_mode_enable_o)
    else $error("data pin enable wrong");
  a_band_valid: assert property (band_valid_o == (band_select_o != 2'h0))
    else $error("band valid wrong");
  a_load_cap: assert property (xtal_load_halfpf_o == 6'h11 + {2'h0, xtal_load_cap_o})
    else $error("load cap scale wrong");
  a_tx_start: assert property (tx_start_o == (pa_en_o && tx_data_register_enable_o))
    else $error("tx start wrong");
  a_cal_skip: assert property (bb_cal_skip_o |-> baseband_en_o && !bb_cal_start_o)
    else $error("calibration not skipped");
endmodule
bind rcpc_top rcpc_top_asserts u_chk (.*);

// ==== testbench/rcpc_host_model.sv ====
`timescale 1ns/1ps
module rcpc_host_model (
  // serial command link
  output logic spi_sck_o,
  output logic spi_sel_n_o,
  output logic spi_sdi_o
);
  // link idles with clock low and select high
  initial begin
    spi_sck_o = 1'b0;
    spi_sel_n_o = 1'b1;
    spi_sdi_o = 1'b0;
  end
  // one 16 bit word, msb first, 80 ns link period, clock stops after
  task automatic send(input logic [15:0] w);
    int i;
    #13 spi_sel_n_o = 1'b0;
    for (i = 15; i >= 0; i--) begin
      spi_sdi_o = w[i];
      #20 spi_sck_o = 1'b1;
      #40 spi_sck_o = 1'b0;
      #20;
    end
    #10 spi_sel_n_o = 1'b1;
    // released data line shows the inverse, not the last bit
    spi_sdi_o = ~w[0];
  endtask
endmodule

// ==== testbench/rcpc_top_test.sv ====
`timescale 1ns/1ps
module rcpc_top_test;
  logic clock_i, rst_i, irq_pending_i, sck, sel_n, sdi;
  logic [22:0] exp_q[$];
  logic [15:0] cfg, pwr;
  logic [31:0] r;
  integer seed;
  int failures, comparisons, i, n;
  event got;
  wire logic [1:0] band;
  wire logic [3:0] cap;
  wire logic [5:0] halfpf;
  wire logic osc, syn, bb, fe, pa, rxm, txm, ts, lbd, wut, clko, treg, fifo, dpoe, valid;
  wire logic strd;
  //////////////////////////////////////////////////////////////////////
  // design and host
  rcpc_host_model u_host (.spi_sck_o(sck), .spi_sel_n_o(sel_n), .spi_sdi_o(sdi));
  rcpc_top u_dut (
    .clock_i(clock_i), .rst_i(rst_i), .spi_sck_i(sck), .spi_sel_n_i(sel_n),
    .spi_sdi_i(sdi), .irq_pending_i(irq_pending_i),
    .tx_data_register_enable_o(treg), .fifo_mode_enable_o(fifo),
    .data_pin_out_en_o(dpoe), .band_select_o(band), .band_valid_o(valid),
    .xtal_load_cap_o(cap), .xtal_load_halfpf_o(halfpf), .xtal_osc_run_o(osc),
    .synth_en_o(syn), .baseband_en_o(bb), .rx_frontend_en_o(fe), .pa_en_o(pa),
    .rx_mode_o(rxm), .tx_mode_o(txm), .tx_start_o(ts), .low_batt_detect_en_o(lbd),
    .wakeup_timer_en_o(wut), .clk_out_en_o(clko), .bb_cal_start_o(),
    .bb_cal_skip_o(), .status_read_o(strd));
  //////////////////////////////////////////////////////////////////////
  // expected outputs from both words and the oscillator state
  function automatic logic [22:0] want(input logic [15:0] c, p, input logic o);
    logic s;
    s = (p[4] | p[7] | p[5]) & o;
    return {o, s, (p[6] | p[7]) & s, p[7] & s, p[5] & ~p[7] & s, p[7], p[5] & ~p[7],
            p[5] & ~p[7] & s & c[7], p[2], p[1], o & ~p[0], c[7], c[6], ~c[6],
            c[5:4], |c[5:4], 6'h11 + {2'h0, c[3:0]}};
  endfunction
  // compare and count
  task automatic check(input string nm, input logic [22:0] s, e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  // print verdict and stop
  task finish_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // note an expected output set for the watcher
  task automatic note(input logic o);
    exp_q.push_back(want(cfg, pwr, o));
    -> got;
  endtask
  // send a word, track the words it hits, then note
  task automatic put(input logic [15:0] w, input logic o);
    int sr;
    sr = 0;
    u_host.send(w);
    if (w[15:8] == 8'h80) cfg = w;
    if (w[15:8] == 8'h82) pwr = w;
    // count status read pulses, sampled after the outputs settle
    repeat (8) begin
      @(posedge clock_i);
      #1 sr += int'(strd);
    end
    check("status", 23'(sr), {22'h0, ~w[15]});
    note(o);
  endtask
  // bounded wait for the oscillator level, counting cycles
  task automatic wait_osc(input logic lvl, output int k);
    k = 0;
    while (osc !== lvl && k < 400) begin
      @(posedge clock_i);
      #1;
      k++;
    end
    if (k >= 400) begin
      failures++;
      finish_test;
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  // watcher takes the oldest note and compares
  initial forever begin
    @(got);
    #1 check("outputs", {osc, syn, bb, fe, pa, rxm, txm, ts, lbd, wut, clko, treg, fifo,
                         dpoe, band, valid, halfpf}, exp_q.pop_front());
  end
  // system clock
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  // main sequence
  initial begin
    rst_i = 1'b1;
    irq_pending_i = 1'b0;
    seed = 44075;
    cfg = 16'h8008;
    pwr = 16'h8208;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    note(1'b1);
    // every band code, load cap at both ends
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      put({8'h80, r[7:6], i[1:0], (i == 0) ? 4'h0 : (i == 3) ? 4'hf : r[3:0]}, 1'b1);
    end
    // receive and transmit combinations, clock disable both ways
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      put({8'h82, i[2], r[6], i[1], r[4], 1'b1, r[2:1], i[0]}, 1'b1);
    end
    put(16'h80c5, 1'b1);
    put(16'h82a8, 1'b1);
    put(16'h8248, 1'b1);
    put(16'h82c8, 1'b1);
    put(16'ha680, 1'b1);
    put(16'h8208, 1'b1);
    // status read then clear oscillator: delayed shutdown
    put(16'h0000, 1'b1);
    u_host.send(16'h8200);
    pwr = 16'h8200;
    wait_osc(1'b0, n);
    check("tail", {22'h0, n >= 193 && n <= 202}, 23'h1);
    note(1'b0);
    // no status read: immediate stop
    put(16'h8208, 1'b1);
    u_host.send(16'h8200);
    pwr = 16'h8200;
    wait_osc(1'b0, n);
    check("cut", {22'h0, n <= 8}, 23'h1);
    // interrupt wakes the oscillator and blocks turn off
    @(posedge clock_i);
    irq_pending_i <= 1'b1;
    wait_osc(1'b1, n);
    check("wake", {22'h0, n <= 4}, 23'h1);
    put(16'h8200, 1'b1);
    @(posedge clock_i);
    irq_pending_i <= 1'b0;
    // host reads status once the source is gone
    u_host.send(16'h0000);
    wait_osc(1'b0, n);
    check("auto", {22'h0, n >= 193 && n <= 202}, 23'h1);
    // clock output disabled: interrupts have no effect
    put(16'h8201, 1'b0);
    @(posedge clock_i);
    irq_pending_i <= 1'b1;
    repeat (10) @(posedge clock_i);
    note(1'b0);
    repeat (2) @(posedge clock_i);
    finish_test;
  end
endmodule
